// >>> hw/lprs_cfg.svh
/*
  Timing and selection constants of the long-press reset supervisor.
  Assumes the system clock runs at the rate given here.
*/
`ifndef LPRS_CFG_SVH
`define LPRS_CFG_SVH

// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define LPRS_CLK_HZ 40000000
`define LPRS_CYC_PER_MS (`LPRS_CLK_HZ / 1000)

// ---------------------------------------------------------------
// reset timeout and input debounce times, in ms
// ---------------------------------------------------------------
`define LPRS_TOUT_MIN_MS 140
`define LPRS_TOUT_MS 210
`define LPRS_IMM_DEB_MS 210
`define LPRS_REL_DEB_MS 20

// ---------------------------------------------------------------
// manual setup period choices, in ms
// ---------------------------------------------------------------
`define LPRS_SETUP_K_MS 10080
`define LPRS_SETUP_L_MS 6720
`define LPRS_SETUP_S_MS 3360
`define LPRS_SETUP_T_MS 1680
`define LPRS_SETUP_SEL_RST 2'h1

`endif

// >>> hw/lprs_pkg.sv
/*
  Types of the long-press reset supervisor.
  Assumes nothing of its surroundings.
*/
package lprs_pkg;

  // ---------------------------------------------------------------
  // build variants
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LPRS_SINGLE = 2'h0,
    LPRS_DUAL = 2'h1,
    LPRS_MIXED = 2'h2
  } lprs_variant_e;

  typedef enum logic [1:0] {
    LPRS_SETUP_K = 2'h0,
    LPRS_SETUP_L = 2'h1,
    LPRS_SETUP_S = 2'h2,
    LPRS_SETUP_T = 2'h3
  } lprs_setup_e;

  // ---------------------------------------------------------------
  // manual sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LPRS_MAN_IDLE = 3'h1,
    LPRS_MAN_SETUP = 3'h2,
    LPRS_MAN_FIRED = 3'h4
  } lprs_man_e;

  // ---------------------------------------------------------------
  // sampled input pins
  // ---------------------------------------------------------------
  typedef struct packed {
    logic vcc_uv;
    logic aux_uv;
    logic long_a_n;
    logic second;
  } lprs_pins_s;

endpackage : lprs_pkg

// >>> hw/lprs_timer.sv
/*
  Saturating interval timer: counts cycles since the last clear.
  Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module lprs_timer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control
  input wire logic clr_i,
  input wire logic [31:0] limit_i,
  // status
  output logic done_o
);

  logic [31:0] cnt_q;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || clr_i) begin
      cnt_q <= 32'h0000_0000;
    end else if (!done_o) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  assign done_o = (cnt_q >= limit_i);

endmodule : lprs_timer

`default_nettype wire

// >>> hw/lprs_top.sv
/*
  Long-press reset supervisor: under-voltage timeout, long-press manual
  reset and optional immediate manual reset, merged into one active-low
  processor reset.
  Assumes asynchronous pins, a 40 MHz system clock and a synchronous
  active-high reset.
*/
// Function
// RULE_01 - reset goes low at once on supply or aux under-voltage
// RULE_02 - after voltages recover, reset stays low one timeout, then high
// RULE_03 - long-press input asserts reset only after full continuous setup
// RULE_04 - completed setup gives one low pulse of one timeout
// RULE_05 - dual variant counts setup only while both inputs are low
// RULE_06 - no new pulse until an input releases and setup repeats
// RULE_07 - releases of long-press inputs are debounced internally
// RULE_08 - mixed variant: immediate input rising edge pulses reset at once
// RULE_09 - another rising edge during timeout restarts the timeout
// RULE_10 - release only after a full quiet timeout of 210ms
// RULE_11 - immediate input falling edges debounced for 210ms
// RULE_12 - one long-press plus one immediate input variant supported
// RULE_13 - operator holds both buttons for the whole setup period
// RULE_14 - setup period chosen at build time among four values
// RULE_15 - broken low condition restarts setup count from zero
// RULE_16 - reset low while any source active; timing in clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "lprs_cfg.svh"

module lprs_top import lprs_pkg::*; #(
  parameter lprs_variant_e VARIANT = LPRS_SINGLE,
  parameter lprs_setup_e SETUP_SEL = lprs_setup_e'(`LPRS_SETUP_SEL_RST),
  parameter bit AUX_EN = 1'b1,
  parameter int unsigned TOUT_CYC = `LPRS_TOUT_MS * `LPRS_CYC_PER_MS,
  parameter int unsigned IMM_DEB_CYC = `LPRS_IMM_DEB_MS * `LPRS_CYC_PER_MS,
  parameter int unsigned REL_DEB_CYC = `LPRS_REL_DEB_MS * `LPRS_CYC_PER_MS,
  parameter int unsigned SETUP_CYC =
    (SETUP_SEL == LPRS_SETUP_K) ? `LPRS_SETUP_K_MS * `LPRS_CYC_PER_MS :
    (SETUP_SEL == LPRS_SETUP_L) ? `LPRS_SETUP_L_MS * `LPRS_CYC_PER_MS :
    (SETUP_SEL == LPRS_SETUP_S) ? `LPRS_SETUP_S_MS * `LPRS_CYC_PER_MS :
    `LPRS_SETUP_T_MS * `LPRS_CYC_PER_MS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // voltage monitors, high while under threshold
  input wire logic vcc_uv_i,
  input wire logic aux_voltage_sense_i,
  // manual inputs
  input wire logic long_press_input_a_n_i,
  input wire logic second_manual_input_i,
  // processor reset
  output logic reset_n_o
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  lprs_pins_s pins_m_q;
  lprs_pins_s pins_s_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pins_m_q <= '{1'b1, 1'b1, 1'b1, 1'b1};
      pins_s_q <= '{1'b1, 1'b1, 1'b1, 1'b1};
    end else begin
      pins_m_q <= '{vcc_uv_i, aux_voltage_sense_i,
                    long_press_input_a_n_i, second_manual_input_i};
      pins_s_q <= pins_m_q;
    end
  end

  logic uv_any;
  logic [1:0] raw_low;

  assign uv_any = pins_s_q.vcc_uv | (AUX_EN & pins_s_q.aux_uv); // [RULE_01]
  assign raw_low = {~pins_s_q.second, ~pins_s_q.long_a_n};

  // ---------------------------------------------------------------
  // under-voltage timeout
  // ---------------------------------------------------------------
  logic uv_done;

  lprs_timer u_uv_tmr (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clr_i(uv_any),
    .limit_i(TOUT_CYC[31:0]),
    .done_o(uv_done)
  ); // [RULE_02]

  // ---------------------------------------------------------------
  // long-press release debounce
  // ---------------------------------------------------------------
  logic [1:0] ext_low_q;
  logic [1:0] rel_done;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_ext
      lprs_timer u_rel_tmr (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clr_i(raw_low[i]),
        .limit_i(REL_DEB_CYC[31:0]),
        .done_o(rel_done[i])
      );

      // low at once, high only after a stable release
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          ext_low_q[i] <= 1'b0;
        end else if (raw_low[i]) begin
          ext_low_q[i] <= 1'b1;
        end else if (rel_done[i]) begin
          ext_low_q[i] <= 1'b0; // [RULE_07]
        end
      end
    end
  endgenerate

  logic man_cond;

  assign man_cond = ext_low_q[0] &
    ((VARIANT == LPRS_DUAL) ? ext_low_q[1] : 1'b1); // [RULE_05] [RULE_13]

  // ---------------------------------------------------------------
  // manual setup sequencer
  // ---------------------------------------------------------------
  lprs_man_e man_q;
  lprs_man_e man_d;
  logic setup_done;
  logic man_fire;

  lprs_timer u_setup_tmr (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clr_i(man_q != LPRS_MAN_SETUP),
    .limit_i(SETUP_CYC[31:0]),
    .done_o(setup_done)
  ); // [RULE_14] [RULE_15]

  always_comb begin
    man_d = man_q;
    man_fire = 1'b0;
    case (man_q)
      LPRS_MAN_IDLE: begin
        if (man_cond) begin
          man_d = LPRS_MAN_SETUP;
        end
      end
      LPRS_MAN_SETUP: begin
        if (!man_cond) begin
          man_d = LPRS_MAN_IDLE; // [RULE_15]
        end else if (setup_done) begin
          man_d = LPRS_MAN_FIRED;
          man_fire = 1'b1; // [RULE_03]
        end
      end
      LPRS_MAN_FIRED: begin
        if (!man_cond) begin
          man_d = LPRS_MAN_IDLE; // [RULE_06]
        end
      end
      default: begin
        man_d = LPRS_MAN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      man_q <= LPRS_MAN_IDLE;
    end else begin
      man_q <= man_d;
    end
  end

  // ---------------------------------------------------------------
  // immediate input, mixed variant only
  // ---------------------------------------------------------------
  logic imm_hi_q;
  logic imm_done;
  logic imm_edge;

  lprs_timer u_imm_tmr (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clr_i(pins_s_q.second),
    .limit_i(IMM_DEB_CYC[31:0]),
    .done_o(imm_done)
  );

  assign imm_edge = (VARIANT == LPRS_MIXED) &
    pins_s_q.second & ~imm_hi_q; // [RULE_08] [RULE_12]

  // high at once, low only after a stable low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      imm_hi_q <= 1'b1;
    end else if (pins_s_q.second) begin
      imm_hi_q <= 1'b1;
    end else if (imm_done) begin
      imm_hi_q <= 1'b0; // [RULE_11]
    end
  end

  // ---------------------------------------------------------------
  // one-shot reset pulse
  // ---------------------------------------------------------------
  logic trig;
  logic pulse_q;
  logic pulse_done;

  assign trig = man_fire | imm_edge;

  lprs_timer u_pulse_tmr (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clr_i(trig),
    .limit_i(TOUT_CYC[31:0]),
    .done_o(pulse_done)
  ); // [RULE_09]

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pulse_q <= 1'b0;
    end else if (trig) begin
      pulse_q <= 1'b1; // [RULE_04]
    end else if (pulse_done) begin
      pulse_q <= 1'b0; // [RULE_10]
    end
  end

  // ---------------------------------------------------------------
  // reset output
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reset_n_o <= 1'b0;
    end else begin
      reset_n_o <= ~(uv_any | ~uv_done | pulse_q | trig); // [RULE_16]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [31:0] low_run_q;
  logic [31:0] cond_run_q;
  logic [31:0] imm_low_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || reset_n_o) begin
      low_run_q <= 32'h0000_0000;
    end else if (trig) begin
      low_run_q <= 32'h0000_0001;
    end else begin
      low_run_q <= low_run_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !man_cond) begin
      cond_run_q <= 32'h0000_0000;
    end else begin
      cond_run_q <= cond_run_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || pins_s_q.second) begin
      imm_low_q <= 32'h0000_0000;
    end else begin
      imm_low_q <= imm_low_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  uv_assert_a: assert property (uv_any |=> !reset_n_o) // [RULE_01]
    else $error("reset not low during under-voltage");

  uv_hold_a: assert property ( // [RULE_02]
    $fell(uv_any) |=> !reset_n_o [*8])
    else $error("reset released too soon after recovery");

  pulse_len_a: assert property ( // [RULE_04]
    $rose(reset_n_o) |-> low_run_q >= TOUT_CYC)
    else $error("reset low shorter than timeout");

  setup_full_a: assert property ( // [RULE_03]
    man_fire |-> cond_run_q >= SETUP_CYC)
    else $error("manual pulse before full setup");

  dual_both_a: assert property ( // [RULE_05]
    (VARIANT == LPRS_DUAL && !(&ext_low_q)) |=> man_q == LPRS_MAN_IDLE)
    else $error("dual setup counts with one input high");

  no_refire_a: assert property ( // [RULE_06]
    (man_q == LPRS_MAN_FIRED && man_cond) |=> man_q == LPRS_MAN_FIRED)
    else $error("manual pulse rearmed without release");

  rel_deb_a: assert property ( // [RULE_07]
    (ext_low_q[0] && !rel_done[0]) |=> ext_low_q[0])
    else $error("release accepted before debounce");

  imm_pulse_a: assert property ( // [RULE_08]
    imm_edge |=> !reset_n_o && pulse_q)
    else $error("immediate edge did not pulse reset");

  imm_restart_a: assert property ( // [RULE_09]
    imm_edge |=> !pulse_done [*2])
    else $error("timeout not restarted by edge");

  imm_deb_a: assert property ( // [RULE_11]
    $fell(imm_hi_q) |-> imm_low_q >= IMM_DEB_CYC)
    else $error("immediate low accepted before debounce");

  any_src_a: assert property ( // [RULE_16]
    pulse_q |=> !reset_n_o)
    else $error("reset high while pulse active");

  man_fire_c: cover property (man_fire ##1 !reset_n_o);
  imm_retrig_c: cover property (imm_edge ##[1:200] imm_edge);
  uv_release_c: cover property ($fell(uv_any) ##[1:1000] $rose(reset_n_o));
  setup_break_c: cover property (
    man_q == LPRS_MAN_SETUP ##1 man_q == LPRS_MAN_IDLE);

endmodule : lprs_top

`default_nettype wire

// >>> test/lprs_panel.sv
/*
  Far-side model: front-panel buttons, supply monitors and
  the processor reset input, which measures every low pulse it sees.
  Assumes the bench calls drive() and that button pins idle high (pull-ups).
*/
`timescale 1ns/1ps
`default_nettype none

module lprs_panel (
  // clock
  input wire logic clk_sys_i,
  // processor reset input
  input wire logic reset_n_i,
  // pins towards the supervisor
  output logic vcc_uv_o,
  output logic aux_uv_o,
  output logic btn_a_n_o,
  output logic btn_b_o
);
  int pulses = 0;
  int low_len = 0;
  int last_len = 0;

  initial begin
    vcc_uv_o = 1'b0;
    aux_uv_o = 1'b0;
    btn_a_n_o = 1'b1;
    btn_b_o = 1'b1;
  end

  // ---------------------------------------------------------------
  // pin changes, just after a falling edge
  // ---------------------------------------------------------------
  task automatic drive(input logic uv, input logic aux, input logic a_n,
                       input logic b);
    @(negedge clk_sys_i);
    vcc_uv_o = uv;
    aux_uv_o = aux;
    btn_a_n_o = a_n;
    btn_b_o = b;
  endtask : drive

  // ---------------------------------------------------------------
  // processor side: low pulse width and count
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (reset_n_i !== 1'b1) begin
      low_len++;
    end else begin
      if (low_len > 0) begin
        pulses++;
        last_len = low_len;
      end
      low_len = 0;
    end
  end
endmodule : lprs_panel

`default_nettype wire

// >>> test/tb.sv
/*
  Testbench: a dual long-press and a mixed supervisor, each facing a
  panel model; scenarios for under-voltage, long press and immediate input.
  Assumes shortened timing parameters set below, except in dut_t, which keeps full-length timing.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lprs_cfg.svh"

module tb;
  import lprs_pkg::*;
  localparam int unsigned TOUT = 50;
  localparam int unsigned SETUP = 200;
  localparam int unsigned IDEB = 30;
  localparam int unsigned RDEB = 10;
  localparam int unsigned SETUP_T = `LPRS_SETUP_T_MS * `LPRS_CYC_PER_MS;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic rst_d_n, uv_d, aux_d, a_d, b_d;
  logic rst_m_n, uv_m, aux_m, a_m, b_m;
  logic rst_s_n, rst_t_n;
  int fails = 0;
  int total_checks = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  // ---------------------------------------------------------------
  // devices and far sides
  // ---------------------------------------------------------------
  lprs_top #(.VARIANT(LPRS_DUAL), .TOUT_CYC(TOUT), .IMM_DEB_CYC(IDEB),
    .REL_DEB_CYC(RDEB), .SETUP_CYC(SETUP)) dut (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .vcc_uv_i(uv_d), .aux_voltage_sense_i(aux_d),
    .long_press_input_a_n_i(a_d), .second_manual_input_i(b_d),
    .reset_n_o(rst_d_n));
  lprs_panel p_d (.clk_sys_i(clk_sys_i), .reset_n_i(rst_d_n),
    .vcc_uv_o(uv_d), .aux_uv_o(aux_d), .btn_a_n_o(a_d), .btn_b_o(b_d));
  lprs_top #(.VARIANT(LPRS_MIXED), .TOUT_CYC(TOUT), .IMM_DEB_CYC(IDEB),
    .REL_DEB_CYC(RDEB), .SETUP_CYC(SETUP)) dut_mix (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .vcc_uv_i(uv_m), .aux_voltage_sense_i(aux_m),
    .long_press_input_a_n_i(a_m), .second_manual_input_i(b_m),
    .reset_n_o(rst_m_n));
  lprs_panel p_m (.clk_sys_i(clk_sys_i), .reset_n_i(rst_m_n),
    .vcc_uv_o(uv_m), .aux_uv_o(aux_m), .btn_a_n_o(a_m), .btn_b_o(b_m));
  // single variant without aux sense, sharing the dual panel
  lprs_top #(.VARIANT(LPRS_SINGLE), .AUX_EN(1'b0), .TOUT_CYC(TOUT),
    .IMM_DEB_CYC(IDEB), .REL_DEB_CYC(RDEB), .SETUP_CYC(SETUP)) dut_one (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .vcc_uv_i(uv_d),
    .aux_voltage_sense_i(aux_d), .long_press_input_a_n_i(a_d),
    .second_manual_input_i(b_d), .reset_n_o(rst_s_n));
  // full-length timing, build-time setup choice
  lprs_top #(.SETUP_SEL(LPRS_SETUP_T)) dut_t (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .vcc_uv_i(uv_d), .aux_voltage_sense_i(aux_d),
    .long_press_input_a_n_i(a_d), .second_manual_input_i(b_d),
    .reset_n_o(rst_t_n));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : wait_n

  task automatic check_bit(input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : check_bit

  task automatic check_cnt(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : check_cnt

  task automatic close_out;
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_uv;
    for (int k = 0; k < 2; k++) begin
      p_d.drive(k == 0, k == 1, 1'b1, 1'b1);
      wait_n(4);
      check_bit(1'b0, rst_d_n);
      check_bit(k != 0, rst_s_n);
      wait_n(20);
      p_d.drive(1'b0, 1'b0, 1'b1, 1'b1);
      wait_n(TOUT - 4);
      check_bit(1'b0, rst_d_n);
      wait_n(12);
      check_bit(1'b1, rst_d_n);
    end
  endtask : t_uv

  task automatic t_short;
    int b0;
    b0 = p_d.pulses;
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b0);
    wait_n(SETUP - 20);
    p_d.drive(1'b0, 1'b0, 1'b1, 1'b1);
    wait_n(30);
    check_cnt(b0, p_d.pulses);
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b1);
    wait_n(SETUP + 30);
    check_bit(1'b1, rst_d_n);
    check_bit(1'b0, rst_s_n);
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b0);
    wait_n(150);
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b1);
    wait_n(3 * RDEB);
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b0);
    wait_n(150);
    p_d.drive(1'b0, 1'b0, 1'b1, 1'b1);
    wait_n(30);
    check_cnt(b0, p_d.pulses);
  endtask : t_short

  task automatic t_long;
    int b0;
    b0 = p_d.pulses;
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b0);
    wait_n(SETUP - 5);
    check_bit(1'b1, rst_d_n);
    wait_n(15);
    check_bit(1'b0, rst_d_n);
    wait_n(TOUT + SETUP);
    check_cnt(b0 + 1, p_d.pulses);
    check_bit(1'b1, p_d.last_len >= TOUT && p_d.last_len <= TOUT + 4);
    // release shorter than the debounce is not a release
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b1);
    wait_n(RDEB / 2);
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b0);
    wait_n(SETUP + 20);
    check_cnt(b0 + 1, p_d.pulses);
    // bouncing release, then a full new press
    p_d.drive(1'b0, 1'b0, 1'b1, 1'b1);
    wait_n(2);
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b0);
    wait_n(2);
    p_d.drive(1'b0, 1'b0, 1'b1, 1'b1);
    wait_n(3 * RDEB);
    p_d.drive(1'b0, 1'b0, 1'b0, 1'b0);
    wait_n(SETUP + TOUT + 20);
    check_cnt(b0 + 2, p_d.pulses);
    p_d.drive(1'b0, 1'b0, 1'b1, 1'b1);
    wait_n(3 * RDEB);
  endtask : t_long

  task automatic t_imm;
    int b0;
    b0 = p_m.pulses;
    p_m.drive(1'b0, 1'b0, 1'b1, 1'b0);
    wait_n(20);
    check_cnt(b0, p_m.pulses);
    wait_n(IDEB + 10);
    p_m.drive(1'b0, 1'b0, 1'b1, 1'b1);
    wait_n(4);
    check_bit(1'b0, rst_m_n);
    p_m.drive(1'b0, 1'b0, 1'b1, 1'b0);
    wait_n(IDEB + 3);
    p_m.drive(1'b0, 1'b0, 1'b1, 1'b1);
    wait_n(TOUT - 4);
    check_bit(1'b0, rst_m_n);
    wait_n(12);
    check_bit(1'b1, rst_m_n);
    check_cnt(b0 + 1, p_m.pulses);
    p_m.drive(1'b0, 1'b0, 1'b1, 1'b0);
    wait_n(IDEB / 4);
    p_m.drive(1'b0, 1'b0, 1'b1, 1'b1);
    wait_n(TOUT + 10);
    check_cnt(b0 + 1, p_m.pulses);
  endtask : t_imm

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    wait_n(8);
    rst_i = 1'b0;
    wait_n(2);
    check_bit(1'b0, rst_d_n);
    check_cnt(SETUP_T, dut_t.SETUP_CYC);
    wait_n(TOUT + 8);
    check_bit(1'b1, rst_d_n);
    t_uv();
    t_short();
    t_long();
    t_imm();
    check_bit(1'b0, rst_t_n);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    close_out();
  end
endmodule : tb

`default_nettype wire
